// >>> rtl/awd_top.sv
// converter start control and programmable window detector
// assumes the analog converter answers convert_start_o with conv_done_i
// and sar_tick_i pulses once per converter clock, all on clk_i
`timescale 1ns/1ns
// ****************************************
// Overview of operation
// - every completed result is compared against both limits by hardware.
// - the match flag is sticky and readable whether or not irqs are used.
// - greater and less limits are each held as writable high/low bytes.
// - limit ordering alone selects inside or outside detection.
// - greater below less flags results strictly between the two limits.
// - otherwise flags results strictly below less or above greater.
// - single-ended results are 10-bit unsigned with unsigned ordering.
// - differential results are 10-bit two's complement, signed ordering.
// - delayed tracking starts on the chosen trigger, tracks 3 clocks.
// - normal tracking tracks continuously except during conversion.
// ****************************************
module awd_top
    import awd_pkg::*;
(
    input  wire logic        clk_i,            // system clock, 125 MHz
    input  wire logic        rst_i,            // sync reset, active high
    input  wire logic        conv_enable_i,    // converter enabled
    input  wire logic        track_mode_select_i, // 1 = delayed tracking
    input  wire logic [2:0]  start_source_select_i, // trigger select
    input  wire logic        busy_write_one_i, // sw writes 1 to busy bit
    input  wire logic [3:0]  timer_ovf_i,      // overflows, timers 3..0
    input  wire logic        sar_tick_i,       // one converter clock
    input  wire logic        conv_done_i,      // conversion finished
    input  wire logic [9:0]  conv_result_i,    // raw converter code
    input  wire logic        differential_i,   // differential mode
    input  wire logic        left_justify_i,   // left-justified storage
    input  wire logic [3:0]  limit_wr_i,       // limit byte strobes
    input  wire logic [7:0]  limit_data_i,     // limit byte data
    input  wire logic        flag_clear_i,     // clear window flag
    output logic             window_match_flag_o, // sticky match flag
    output logic             conversion_busy_bit_o, // conversion busy
    output logic             tracking_o,       // input being tracked
    output logic             convert_start_o,  // start conversion pulse
    output logic [7:0]       result_high_byte_o, // stored result high
    output logic [7:0]       result_low_byte_o,  // stored result low
    output awd_limits_t      limits_o          // limit readback
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    awd_state_t  state;
    awd_state_t  next_state;
    awd_limits_t limits;
    logic [1:0]  track_cnt;
    logic [15:0] result;
    logic        result_signed;
    logic        eval;
    logic        match;
    logic        trigger;
    logic        window_flag;

    // ****************************************
    // trigger selection
    // ****************************************
    function automatic logic pick_trigger(input logic [2:0] src,
                                          input logic       sw,
                                          input logic [3:0] ovf);
        unique case (src)
            SRC_SOFT: pick_trigger = sw;
            SRC_TMR0: pick_trigger = ovf[0];
            SRC_TMR2: pick_trigger = ovf[2];
            SRC_TMR1: pick_trigger = ovf[1];
            SRC_TMR3: pick_trigger = ovf[3];
            default:  pick_trigger = 1'b0;
        endcase
    endfunction

    assign trigger = conv_enable_i &&
        pick_trigger(start_source_select_i, busy_write_one_i,
                     timer_ovf_i);

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (trigger) begin
                    next_state = track_mode_select_i ? ST_TRACK : ST_CONV;
                end
            end
            ST_TRACK: begin
                if (sar_tick_i && track_cnt == TRACK_CLKS - 2'h1) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_TRACK) begin
            track_cnt <= 2'h0;
        end else if (sar_tick_i) begin
            track_cnt <= track_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            convert_start_o <= 1'b0;
        end else begin
            convert_start_o <= next_state == ST_CONV && state != ST_CONV;
        end
    end

    assign conversion_busy_bit_o = state != ST_IDLE;
    assign tracking_o = conv_enable_i && (track_mode_select_i ?
        state == ST_TRACK : state != ST_CONV);

    // ****************************************
    // limit bytes
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limits.greater <= GT_RESET;
            limits.less    <= LT_RESET;
        end else begin
            if (limit_wr_i[WR_GT_HI]) begin
                limits.greater[15:8] <= limit_data_i;
            end
            if (limit_wr_i[WR_GT_LO]) begin
                limits.greater[7:0]  <= limit_data_i;
            end
            if (limit_wr_i[WR_LT_HI]) begin
                limits.less[15:8]    <= limit_data_i;
            end
            if (limit_wr_i[WR_LT_LO]) begin
                limits.less[7:0]     <= limit_data_i;
            end
        end
    end

    assign limits_o = limits;

    // ****************************************
    // result storage
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result        <= RES_RESET;
            result_signed <= 1'b0;
        end else if (conv_done_i && state == ST_CONV) begin
            result_signed <= differential_i;
            if (left_justify_i) begin
                result <= {conv_result_i, {LJ_PAD{1'b0}}};
            end else if (differential_i) begin
                result <= {{LJ_PAD{conv_result_i[RES_W-1]}},
                           conv_result_i};
            end else begin
                result <= {{LJ_PAD{1'b0}}, conv_result_i};
            end
        end
    end

    assign result_high_byte_o = result[15:8];
    assign result_low_byte_o  = result[7:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eval <= 1'b0;
        end else begin
            eval <= conv_done_i && state == ST_CONV;
        end
    end

    // ****************************************
    // window detector
    // ****************************************
    awd_window_cmp u_cmp (
        .result_i (result),
        .limits_i (limits),
        .signed_i (result_signed),
        .match_o  (match)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            window_flag <= 1'b0;
        end else if (eval && match) begin
            window_flag <= 1'b1;
        end else if (flag_clear_i) begin
            window_flag <= 1'b0;
        end
    end

    assign window_match_flag_o = window_flag;

    // ****************************************
    // checks
    // ****************************************
    a_flag_on_match: assert property (eval && match |=> window_flag)
        else $error("window flag not set on match");
    a_flag_sticky: assert property (window_flag && !flag_clear_i
        |=> window_flag)
        else $error("window flag dropped without clear");
    a_limit_write: assert property (limit_wr_i[WR_GT_HI]
        |=> limits.greater[15:8] == $past(limit_data_i))
        else $error("greater high byte not written");
    a_inside_hit: assert property (eval && !result_signed
        && limits.greater < limits.less && result > limits.greater
        && result < limits.less |=> window_flag)
        else $error("inside hit missed");
    a_inside_miss: assert property (eval && !result_signed
        && limits.greater < limits.less && result == limits.less
        && !window_flag && !flag_clear_i |=> !window_flag)
        else $error("boundary result flagged");
    a_outside_hit: assert property (eval && !result_signed
        && limits.greater >= limits.less && (result < limits.less
        || result > limits.greater) |=> window_flag)
        else $error("outside hit missed");
    a_signed_hit: assert property (eval && result_signed
        && $signed(limits.greater) < $signed(limits.less)
        && $signed(result) > $signed(limits.greater)
        && $signed(result) < $signed(limits.less) |=> window_flag)
        else $error("signed inside hit missed");
    // tracking ticks, counted apart from the sequencer
    logic [2:0] track_ticks;

    always_ff @(posedge clk_i) begin
        if (rst_i || state == ST_IDLE) begin
            track_ticks <= 3'h0;
        end else if (state == ST_TRACK && sar_tick_i) begin
            track_ticks <= track_ticks + 3'h1;
        end
    end

    a_track_entry: assert property (state == ST_IDLE && trigger
        && track_mode_select_i |=> state == ST_TRACK)
        else $error("delayed tracking not entered");
    a_track_three: assert property (state == ST_CONV
        && $past(state == ST_TRACK)
        |-> track_ticks == {1'b0, TRACK_CLKS})
        else $error("delayed tracking length wrong");
    a_start_pulse: assert property (convert_start_o |=> !convert_start_o)
        else $error("start pulse longer than one cycle");
    a_normal_track: assert property (conv_enable_i
        && !track_mode_select_i && state != ST_CONV |-> tracking_o)
        else $error("normal mode not tracking");
    a_conv_no_track: assert property (state == ST_CONV |-> !tracking_o)
        else $error("tracking during conversion");
    a_eval_once: assert property (eval |=> !eval)
        else $error("comparison repeated");
endmodule

// >>> common/awd_pkg.sv
// package for the converter window detector and start control
// assumes a single system clock and a converter clock tick in that domain
package awd_pkg;
    // ****************************************
    // widths and layout
    // ****************************************
    localparam int          RES_W       = 10;
    localparam int          WORD_W      = 16;
    localparam int          LJ_PAD      = 6;
    // ****************************************
    // timing, in converter clocks
    // ****************************************
    localparam logic [1:0]  TRACK_CLKS  = 2'h3;
    // ****************************************
    // start source codes, both tracking modes
    // ****************************************
    localparam logic [2:0]  SRC_SOFT    = 3'h0;
    localparam logic [2:0]  SRC_TMR0    = 3'h1;
    localparam logic [2:0]  SRC_TMR2    = 3'h2;
    localparam logic [2:0]  SRC_TMR1    = 3'h3;
    localparam logic [2:0]  SRC_TMR3    = 3'h5;
    // ****************************************
    // limit byte write strobe positions
    // ****************************************
    localparam int          WR_GT_HI    = 3;
    localparam int          WR_GT_LO    = 2;
    localparam int          WR_LT_HI    = 1;
    localparam int          WR_LT_LO    = 0;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] GT_RESET    = 16'hffff;
    localparam logic [15:0] LT_RESET    = 16'h0000;
    localparam logic [15:0] RES_RESET   = 16'h0000;

    typedef struct packed {
        logic [15:0] greater;
        logic [15:0] less;
    } awd_limits_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV  = 3'b100
    } awd_state_t;
endpackage

// >>> rtl/awd_window_cmp.sv
// window comparison of one stored result word against two limits
// assumes result and limits share the same justification
`timescale 1ns/1ns
module awd_window_cmp
    import awd_pkg::*;
(
    input  wire logic [15:0] result_i,   // stored result word
    input  wire awd_limits_t limits_i,   // greater and less limits
    input  wire logic        signed_i,   // two's complement ordering
    output logic             match_o     // window condition met
);
    // ****************************************
    // ordering
    // ****************************************
    function automatic logic below(input logic [15:0] a,
                                   input logic [15:0] b,
                                   input logic        sgn);
        if (sgn) begin
            below = $signed(a) < $signed(b);
        end else begin
            below = a < b;
        end
    endfunction

    logic inside_mode;
    logic above_gt;
    logic below_lt;

    assign inside_mode = below(limits_i.greater, limits_i.less, signed_i);
    assign above_gt    = below(limits_i.greater, result_i, signed_i);
    assign below_lt    = below(result_i, limits_i.less, signed_i);

    always_comb begin
        if (inside_mode) begin
            match_o = above_gt && below_lt;
        end else begin
            match_o = above_gt || below_lt;
        end
    end
endmodule

// >>> verif/test_awd_top.sv
// self-checking bench for the converter start control and window detector
// assumes the design's own assertions; bench plays converter and software
`timescale 1ns/1ns
module test_awd_top
    import awd_pkg::*;
;
    typedef struct packed {
        logic [15:0] gt;
        logic [15:0] lt;
        logic        diff;
        logic        lj;
        logic [9:0]  code;
        logic        flag;
    } awd_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        en = 1'b1, tm = 1'b0, sw = 1'b0, tick = 1'b0, done = 1'b0;
    logic [2:0]  src = 3'h0;
    logic [3:0]  ovf = 4'h0, wr = 4'h0;
    logic [9:0]  code = 10'h000;
    logic        diff = 1'b0, lj = 1'b0, clr = 1'b0;
    logic [7:0]  wdat = 8'h00;
    logic        flag, busy, trk, start;
    logic [7:0]  rh, rl;
    awd_limits_t lim;
    int          bad_count = 0;
    int          n_compared = 0;
    awd_row_t    rows [12] = '{
        '{16'h0040, 16'h0080, 1'b0, 1'b0, 10'h041, 1'b1},
        '{16'h0040, 16'h0080, 1'b0, 1'b0, 10'h040, 1'b0},
        '{16'h0040, 16'h0080, 1'b0, 1'b0, 10'h080, 1'b0},
        '{16'h0080, 16'h0040, 1'b0, 1'b0, 10'h03f, 1'b1},
        '{16'h0080, 16'h0040, 1'b0, 1'b0, 10'h040, 1'b0},
        '{16'h0080, 16'h0040, 1'b0, 1'b0, 10'h081, 1'b1},
        '{16'hffff, 16'h0040, 1'b1, 1'b0, 10'h000, 1'b1},
        '{16'hffff, 16'h0040, 1'b1, 1'b0, 10'h3ff, 1'b0},
        '{16'hffff, 16'h0040, 1'b1, 1'b0, 10'h200, 1'b0},
        '{16'h0040, 16'hffff, 1'b1, 1'b0, 10'h3fe, 1'b1},
        '{16'h1000, 16'h2000, 1'b0, 1'b1, 10'h041, 1'b1},
        '{16'hffc0, 16'h1000, 1'b1, 1'b1, 10'h3ff, 1'b0}};
    int          tbit [4] = '{0, 2, 1, 3};
    logic [2:0]  tsrc [4] = '{SRC_TMR0, SRC_TMR2, SRC_TMR1, SRC_TMR3};

    always #4 clk_i = ~clk_i;

    awd_top dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .conv_enable_i         (en),
        .track_mode_select_i   (tm),
        .start_source_select_i (src),
        .busy_write_one_i      (sw),
        .timer_ovf_i           (ovf),
        .sar_tick_i            (tick),
        .conv_done_i           (done),
        .conv_result_i         (code),
        .differential_i        (diff),
        .left_justify_i        (lj),
        .limit_wr_i            (wr),
        .limit_data_i          (wdat),
        .flag_clear_i          (clr),
        .window_match_flag_o   (flag),
        .conversion_busy_bit_o (busy),
        .tracking_o            (trk),
        .convert_start_o       (start),
        .result_high_byte_o    (rh),
        .result_low_byte_o     (rl),
        .limits_o              (lim)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask

    task automatic wr_byte(input int b, input logic [7:0] d);
        @(posedge clk_i);
        wr <= 4'h1 << b;
        wdat <= d;
        @(posedge clk_i);
        wr <= 4'h0;
    endtask

    task automatic pulse_trig(input logic s, input logic [3:0] o);
        @(posedge clk_i);
        sw <= s;
        ovf <= o;
        @(posedge clk_i);
        sw <= 1'b0;
        ovf <= 4'h0;
    endtask

    task automatic give_tick();
        @(posedge clk_i);
        tick <= 1'b1;
        @(posedge clk_i);
        tick <= 1'b0;
    endtask

    // waits for the start pulse, answers it, waits for idle
    task automatic finish_conv(input logic [9:0] c);
        int i;
        #1;
        for (i = 0; i < 8 && start !== 1'b1; i++) step();
        if (start !== 1'b1) begin
            bad_count++;
            test_done();
        end
        chk("tracking in conversion", 1'b0, trk);
        @(posedge clk_i);
        done <= 1'b1;
        code <= c;
        @(posedge clk_i);
        done <= 1'b0;
        for (i = 0; i < 8 && busy !== 1'b0; i++) step();
        chk("busy after done", 1'b0, busy);
        repeat (2) step();
    endtask

    function automatic logic [15:0] word(input logic [9:0] c,
                                         input logic d, input logic l);
        if (l) return {c, 6'h00};
        return d ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        step();
        chk("limits at reset", {GT_RESET, LT_RESET}, lim);
        chk("flag busy at reset", 2'h0, {flag, busy});
        chk("result at reset", RES_RESET, {rh, rl});
        chk("idle tracking", 1'b1, trk);
        $display("reset test done");
        foreach (rows[k]) begin
            wr_byte(WR_GT_HI, rows[k].gt[15:8]);
            wr_byte(WR_GT_LO, rows[k].gt[7:0]);
            wr_byte(WR_LT_HI, rows[k].lt[15:8]);
            wr_byte(WR_LT_LO, rows[k].lt[7:0]);
            diff <= rows[k].diff;
            lj <= rows[k].lj;
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            #1;
            chk("limits", {rows[k].gt, rows[k].lt}, lim);
            pulse_trig(1'b1, 4'h0);
            finish_conv(rows[k].code);
            chk("result word", word(rows[k].code, rows[k].diff, rows[k].lj),
                {rh, rl});
            chk("window flag", rows[k].flag, flag);
        end
        $display("table cases done");
        // flag stays set through a non-matching result until cleared
        pulse_trig(1'b1, 4'h0);
        finish_conv(10'h000);
        chk("flag on match", 1'b1, flag);
        pulse_trig(1'b1, 4'h0);
        finish_conv(10'h3fe);
        chk("sticky flag", 1'b1, flag);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        step();
        chk("cleared flag", 1'b0, flag);
        $display("sticky flag test done");
        // a match in the same cycle as a clear leaves the flag set
        @(posedge clk_i);
        clr <= 1'b1;
        pulse_trig(1'b1, 4'h0);
        @(posedge clk_i);
        done <= 1'b1;
        code <= 10'h000;
        @(posedge clk_i);
        done <= 1'b0;
        @(posedge clk_i);
        clr <= 1'b0;
        #1;
        chk("flag set over clear", 1'b1, flag);
        $display("set over clear test done");
        // a disabled converter neither tracks nor starts
        @(posedge clk_i);
        en <= 1'b0;
        pulse_trig(1'b1, 4'h0);
        step();
        chk("disabled busy tracking", 2'h0, {busy, trk});
        @(posedge clk_i);
        en <= 1'b1;
        tm <= 1'b1;
        $display("disabled converter test done");
        // delayed tracking: every trigger source, three ticks before start
        for (int t = 0; t < 5; t++) begin
            @(posedge clk_i);
            src <= (t < 4) ? tsrc[t] : SRC_SOFT;
            pulse_trig(1'b0, (t < 4) ? 4'hf ^ (4'h1 << tbit[t]) : 4'hf);
            step();
            chk("busy on wrong trigger", 1'b0, busy);
            if (t < 4) pulse_trig(1'b0, 4'h1 << tbit[t]);
            else pulse_trig(1'b1, 4'h0);
            give_tick();
            give_tick();
            step();
            chk("busy tracking", 2'h3, {busy, trk});
            chk("early start", 1'b0, start);
            give_tick();
            finish_conv(10'h000);
        end
        $display("delayed tracking test done");
        // reserved codes 4, 6 and 7 never start a conversion
        for (int c = 4; c < 8; c++) begin
            if (c == 5) continue;
            @(posedge clk_i);
            tm <= 1'b0;
            src <= c[2:0];
            pulse_trig(1'b1, 4'hf);
            repeat (3) step();
            chk("busy on reserved code", 1'b0, busy);
        end
        $display("reserved code test done");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
endmodule
